/* File: lane_err_map.svh */
`ifndef LANE_ERR_MAP_SVH
`define LANE_ERR_MAP_SVH

// Register offsets on the configuration port
`define ADDR_LANE6_CTRL 12'h486
`define ADDR_LANE7_CTRL 12'h487
`define ADDR_LANE0_SAT 12'h488

// Field positions inside the lane control and saturate registers
`define ENA_MSB 5
`define ENA_LSB 3
`define CLR_MSB 2
`define CLR_LSB 0
`define SAT_MSB 2
`define SAT_LSB 0

// Error type positions within every 3-bit field
`define ERR_UNEXP_CTRL 2
`define ERR_INVALID 1
`define ERR_DISP 0

// Reset values and writable masks
`define CTRL_RESET 8'h3f
`define CTRL_WMASK 8'h3f
`define SAT_RESET 8'h07
`define SAT_WMASK 8'h07
`define READ_ZERO 8'h00

// Counter limits
`define COUNT_MAX 8'hff
`define COUNT_ZERO 8'h00
`define COUNT_STEP 8'h01

`endif

/* File: lane_err_pkg.sv */
package lane_err_pkg;
    // One error counter value
    typedef logic [7:0] count_t;
    // One bit per error type: unexpected control, invalid code, disparity
    typedef logic [2:0] err_vec_t;
    // Register offset on the configuration port
    typedef logic [11:0] reg_addr_t;
endpackage : lane_err_pkg

/* File: lane_err_counters.sv */
`timescale 1ns/10ps
`include "lane_err_map.svh"

module lane_err_counters (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire lane_err_pkg::err_vec_t errors,
    input wire lane_err_pkg::err_vec_t enables,
    input wire lane_err_pkg::err_vec_t clears,
    input wire lane_err_pkg::err_vec_t saturate,
    output lane_err_pkg::count_t counts [3]
);

    lane_err_pkg::count_t next_counts [3];

    // One counter per error type, indexed by the field bit position
    for (genvar i = 0; i < 3; i++) begin : g_cnt
        // Clear dominates so a held clear bit pins the counter at zero
        always_comb begin
            next_counts[i] = counts[i];
            if (clears[i] || soft_reset) begin
                next_counts[i] = `COUNT_ZERO;
            end else if (enables[i] && errors[i]) begin
                if (saturate[i] && (counts[i] == `COUNT_MAX)) begin
                    next_counts[i] = `COUNT_MAX;
                end else begin
                    next_counts[i] = counts[i] + `COUNT_STEP;
                end
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                counts[i] <= `COUNT_ZERO;
            end else begin
                counts[i] <= next_counts[i];
            end
        end
    end

endmodule : lane_err_counters

/* File: lane_decode_error_counters.sv */
//Contract
//- Field bit 2 unexpected control, bit 1 invalid code, bit 0 disparity.
//- Lanes 6 and 7 enable bits [5:3] gate counting, reset to all on.
//- Clear bits [2:0] hold the matching counter at zero, reset to 0x7.
//- With saturate bit set, counter stops at 0xff until the user clears it.
//- With saturate bit clear, counter wraps from maximum to zero.
//- Lane 0 saturate field at bits [2:0], one per type, reset 0x7.
`timescale 1ns/10ps
`include "lane_err_map.svh"

module lane_decode_error_counters (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic deserializer_core_soft_reset,
    input wire lane_err_pkg::reg_addr_t reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire lane_err_pkg::err_vec_t lane0_errors,
    input wire lane_err_pkg::err_vec_t lane6_errors,
    input wire lane_err_pkg::err_vec_t lane7_errors,
    input wire lane_err_pkg::err_vec_t lane0_count_enables,
    input wire lane_err_pkg::err_vec_t lane0_count_clears,
    input wire lane_err_pkg::err_vec_t lane6_saturate_enables,
    input wire lane_err_pkg::err_vec_t lane7_saturate_enables,
    output lane_err_pkg::count_t lane0_counts [3],
    output lane_err_pkg::count_t lane6_counts [3],
    output lane_err_pkg::count_t lane7_counts [3]
);

    logic [7:0] lane6_error_count_control;
    logic [7:0] lane7_error_count_control;
    logic [7:0] lane0_error_count_saturate;
    logic [7:0] next_lane6_ctrl;
    logic [7:0] next_lane7_ctrl;
    logic [7:0] next_lane0_sat;
    logic [7:0] next_rdata;

    // Register writes; reserved bits are masked so they always read zero
    always_comb begin
        next_lane6_ctrl = lane6_error_count_control;
        next_lane7_ctrl = lane7_error_count_control;
        next_lane0_sat = lane0_error_count_saturate;
        if (reg_write) begin
            unique case (reg_addr)
                `ADDR_LANE6_CTRL: next_lane6_ctrl = reg_wdata & `CTRL_WMASK;
                `ADDR_LANE7_CTRL: next_lane7_ctrl = reg_wdata & `CTRL_WMASK;
                // Taken at any time; only safe while the core is in soft reset
                `ADDR_LANE0_SAT: next_lane0_sat = reg_wdata & `SAT_WMASK;
                default: ;
            endcase
        end
    end

    // Read mux registered so the data port comes from a flip-flop
    always_comb begin
        unique case (reg_addr)
            `ADDR_LANE6_CTRL: next_rdata = next_lane6_ctrl;
            `ADDR_LANE7_CTRL: next_rdata = next_lane7_ctrl;
            `ADDR_LANE0_SAT: next_rdata = next_lane0_sat;
            default: next_rdata = `READ_ZERO;
        endcase
    end

    // Defaults leave every lane 6 and lane 7 counter enabled but held in clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lane6_error_count_control <= `CTRL_RESET;
            lane7_error_count_control <= `CTRL_RESET;
            lane0_error_count_saturate <= `SAT_RESET;
            reg_rdata <= `READ_ZERO;
        end else begin
            lane6_error_count_control <= next_lane6_ctrl;
            lane7_error_count_control <= next_lane7_ctrl;
            lane0_error_count_saturate <= next_lane0_sat;
            reg_rdata <= next_rdata;
        end
    end

    // Lane 0: enables and clears come from input ports, saturate from its register
    lane_err_counters u_lane0 (
        .mclk(mclk),
        .rst_n(rst_n),
        .soft_reset(deserializer_core_soft_reset),
        .errors(lane0_errors),
        .enables(lane0_count_enables),
        .clears(lane0_count_clears),
        .saturate(lane0_error_count_saturate[`SAT_MSB:`SAT_LSB]),
        .counts(lane0_counts)
    );

    // Lane 6: enable and clear fields from its control register
    lane_err_counters u_lane6 (
        .mclk(mclk),
        .rst_n(rst_n),
        .soft_reset(deserializer_core_soft_reset),
        .errors(lane6_errors),
        .enables(lane6_error_count_control[`ENA_MSB:`ENA_LSB]),
        .clears(lane6_error_count_control[`CLR_MSB:`CLR_LSB]),
        .saturate(lane6_saturate_enables),
        .counts(lane6_counts)
    );

    // Lane 7: enable and clear fields from its control register
    lane_err_counters u_lane7 (
        .mclk(mclk),
        .rst_n(rst_n),
        .soft_reset(deserializer_core_soft_reset),
        .errors(lane7_errors),
        .enables(lane7_error_count_control[`ENA_MSB:`ENA_LSB]),
        .clears(lane7_error_count_control[`CLR_MSB:`CLR_LSB]),
        .saturate(lane7_saturate_enables),
        .counts(lane7_counts)
    );

endmodule : lane_decode_error_counters

/* File: lane_decode_error_counters_asserts.sv */
`timescale 1ns/10ps
module lane_decode_error_counters_asserts (
    input logic mclk,
    input logic rst_n,
    input logic deserializer_core_soft_reset,
    input lane_err_pkg::reg_addr_t reg_addr,
    input logic reg_write,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input lane_err_pkg::err_vec_t lane0_errors,
    input lane_err_pkg::err_vec_t lane0_count_enables,
    input lane_err_pkg::err_vec_t lane0_count_clears,
    input lane_err_pkg::count_t lane0_counts [3],
    input lane_err_pkg::count_t lane7_counts [3]
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Readback one edge after the write, reserved bits dropped
    chk_ctrl_write: assert property (reg_write && reg_addr == 12'h486 |=>
        reg_rdata == ($past(reg_wdata) & 8'h3f)) else $error("ctrl readback wrong");
    chk_sat_write: assert property (reg_write && reg_addr == 12'h488 |=>
        reg_rdata == ($past(reg_wdata) & 8'h07)) else $error("saturate readback wrong");
    chk_unmapped_zero: assert property (!(reg_addr inside {12'h486, 12'h487, 12'h488})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    // Lane 0 enables and clears are ports but saturate is a register, so its counters are checked exactly below 0xff; at 0xff hold or wrap both pass
    for (genvar i = 0; i < 3; i++) begin : g_type
        logic go;
        assign go = lane0_errors[i] && lane0_count_enables[i] && !lane0_count_clears[i]
            && !deserializer_core_soft_reset;
        chk_lane0_clear: assert property (lane0_count_clears[i] |=> lane0_counts[i] == 8'h00)
            else $error("clear did not zero");
        chk_lane0_hold: assert property (!lane0_count_enables[i] && !lane0_count_clears[i]
            && !deserializer_core_soft_reset |=> $stable(lane0_counts[i])) else $error("hold moved");
        chk_lane0_step: assert property (go && lane0_counts[i] != 8'hff |=>
            lane0_counts[i] == $past(lane0_counts[i]) + 8'h01) else $error("step wrong");
        chk_lane0_top: assert property (go && lane0_counts[i] == 8'hff |=>
            lane0_counts[i] inside {8'hff, 8'h00}) else $error("top value wrong");
        chk_soft_zero: assert property (deserializer_core_soft_reset |=>
            lane7_counts[i] == 8'h00) else $error("soft reset did not zero");
    end
endmodule : lane_decode_error_counters_asserts
bind lane_decode_error_counters lane_decode_error_counters_asserts i_chk (.*);

/* File: lane_decode_error_counters_test.sv */
`timescale 1ns/10ps
module lane_decode_error_counters_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic deserializer_core_soft_reset = 1'b0;
    logic reg_write = 1'b0;
    lane_err_pkg::reg_addr_t reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    lane_err_pkg::err_vec_t lane0_errors = 3'h0, lane6_errors = 3'h0, lane7_errors = 3'h0;
    lane_err_pkg::err_vec_t lane0_count_enables = 3'h7, lane0_count_clears = 3'h0;
    lane_err_pkg::err_vec_t lane6_saturate_enables = 3'h0, lane7_saturate_enables = 3'h0;
    lane_err_pkg::count_t lane0_counts [3], lane6_counts [3], lane7_counts [3];
    int n_fail = 0;
    int checks = 0;
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    lane_decode_error_counters i_lane_decode_error_counters (.*);
    task ck(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : ck
    task cc(input string nm, input lane_err_pkg::count_t g [3], input logic [7:0] x2, x1, x0);
        ck(nm, x2, g[2]);
        ck(nm, x1, g[1]);
        ck(nm, x0, g[0]);
    endtask : cc
    // One-cycle write strobe; an idle cycle after it keeps strobes apart
    task wr(input lane_err_pkg::reg_addr_t a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge mclk);
        reg_write = 1'b0;
        @(negedge mclk);
    endtask : wr
    task rd(input lane_err_pkg::reg_addr_t a, input logic [7:0] e);
        reg_addr = a;
        @(negedge mclk);
        ck("reg_rdata", e, reg_rdata);
    endtask : rd
    // All error types on every lane; idle cycle after so no double drive
    task pulse(input int n);
        {lane0_errors, lane6_errors, lane7_errors} = 9'h1ff;
        repeat (n) @(negedge mclk);
        {lane0_errors, lane6_errors, lane7_errors} = 9'h000;
        @(negedge mclk);
    endtask : pulse
    task give_verdict;
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        rd(12'h486, 8'h3f);
        rd(12'h487, 8'h3f);
        rd(12'h488, 8'h07);
        rd(12'h489, 8'h00);
        wr(12'h486, 8'hff);
        rd(12'h486, 8'h3f);
        pulse(2);
        cc("lane6_counts", lane6_counts, 8'h00, 8'h00, 8'h00);
        cc("lane7_counts", lane7_counts, 8'h00, 8'h00, 8'h00);
        wr(12'h486, 8'h38);
        wr(12'h487, 8'h28);
        pulse(3);
        cc("lane6_counts", lane6_counts, 8'h03, 8'h03, 8'h03);
        cc("lane7_counts", lane7_counts, 8'h03, 8'h00, 8'h03);
        lane6_saturate_enables = 3'h1;
        lane7_saturate_enables = 3'h5;
        pulse(254);
        cc("lane6_counts", lane6_counts, 8'h01, 8'h01, 8'hff);
        cc("lane7_counts", lane7_counts, 8'hff, 8'h00, 8'hff);
        cc("lane0_counts", lane0_counts, 8'hff, 8'hff, 8'hff);
        wr(12'h486, 8'h3e);
        cc("lane6_counts", lane6_counts, 8'h00, 8'h00, 8'hff);
        // Saturate field changed only under soft reset
        deserializer_core_soft_reset = 1'b1;
        wr(12'h488, 8'h02);
        deserializer_core_soft_reset = 1'b0;
        rd(12'h488, 8'h02);
        cc("lane0_counts", lane0_counts, 8'h00, 8'h00, 8'h00);
        pulse(257);
        cc("lane0_counts", lane0_counts, 8'h01, 8'hff, 8'h01);
        cc("lane7_counts", lane7_counts, 8'hff, 8'h00, 8'hff);
        lane0_count_enables = 3'h5;
        lane0_count_clears = 3'h4;
        pulse(1);
        cc("lane0_counts", lane0_counts, 8'h00, 8'hff, 8'h02);
        cc("lane7_counts", lane7_counts, 8'hff, 8'h00, 8'hff);
        give_verdict();
    end
    // Run needs about 540 cycles
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        give_verdict();
    end
endmodule : lane_decode_error_counters_test
